// >>> hw/ioexp_defs.svh
// Constants for the serial I/O expander: addresses, commands, resets, widths
`ifndef IOEXP_DEFS_SVH
`define IOEXP_DEFS_SVH

// ----------------------------------------------------------------------
// Serial address
// ----------------------------------------------------------------------
`define IOEXP_ADDR_HI   5'h16
`define IOEXP_ADDR_LO   1'h0
`define IOEXP_BYTE_BITS 4'h8
`define IOEXP_LAST_TX   4'h7

// ----------------------------------------------------------------------
// Command byte layout: codes 00h..07h, bit 0 picks the group
// ----------------------------------------------------------------------
`define IOEXP_CMD_TOP   7
`define IOEXP_CMD_HI    3
`define IOEXP_CMD_GRP   0

// ----------------------------------------------------------------------
// Port data: four ports per group, carried in the upper nibble
// ----------------------------------------------------------------------
`define IOEXP_NIB       4
`define IOEXP_NIB_LSB   4
`define IOEXP_DIR_RST   4'h0
`define IOEXP_MASK_RST  4'h0
`define IOEXP_OUT_RST   4'h0

// ----------------------------------------------------------------------
// Pin synchroniser: 12 sampled inputs, idle bus levels high
// ----------------------------------------------------------------------
`define IOEXP_SYNC_W    12
`define IOEXP_SYNC_RST  12'he00
`define IOEXP_STRAP_AT  2'h2

`endif

// >>> hw/ioexp_pkg.sv
// Types shared by the expander modules
package ioexp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RX     = 3'h1,
    ST_ACK    = 3'h3,
    ST_TX     = 3'h2,
    ST_MACK   = 3'h6,
    ST_IGNORE = 3'h4
  } ioexp_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_CMD  = 2'h1,
    PH_DATA = 2'h3
  } ioexp_phase_t;

  typedef enum logic [1:0] {
    KIND_IN   = 2'h0,
    KIND_OUT  = 2'h1,
    KIND_DIR  = 2'h2,
    KIND_MASK = 2'h3
  } ioexp_kind_t;

endpackage

// >>> hw/ioexp_grp_if.sv
// Link between the serial front end and one four-port group
`include "ioexp_defs.svh"
interface ioexp_grp_if;
  import ioexp_pkg::*;
  logic [`IOEXP_NIB-1:0] pin_in;
  logic [`IOEXP_NIB-1:0] wr_data;
  logic [`IOEXP_NIB-1:0] out_reg;
  logic [`IOEXP_NIB-1:0] dir;
  logic [`IOEXP_NIB-1:0] mask;
  logic [`IOEXP_NIB-1:0] snapshot;
  logic                  wr_en;
  ioexp_kind_t           wr_kind;
  logic                  capture;
  logic                  strap_load;
  logic                  strap_val;
  logic                  pending;

  modport top (
    output pin_in, wr_data, wr_en, wr_kind, capture, strap_load, strap_val,
    input  out_reg, dir, mask, snapshot, pending
  );
  modport grp (
    input  pin_in, wr_data, wr_en, wr_kind, capture, strap_load, strap_val,
    output out_reg, dir, mask, snapshot, pending
  );
endinterface

// >>> hw/ioexp_grp.sv
// One group of four ports: registers, pin drive and change detection
`include "ioexp_defs.svh"
module ioexp_grp #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  ioexp_grp_if.grp                    gi,
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  output logic [`IOEXP_NIB-1:0]       pin_out,
  output logic [`IOEXP_NIB-1:0]       pin_oe
);
  import ioexp_pkg::*;

  logic [`IOEXP_NIB-1:0] diff;

  // ----------------------------------------------------------------------
  // Registers written over the serial bus
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gi.out_reg <= `IOEXP_OUT_RST;
      gi.dir     <= `IOEXP_DIR_RST;
      gi.mask    <= `IOEXP_MASK_RST;
    end else if (gi.strap_load) begin
      // Power-up level follows the address strap
      gi.out_reg <= {`IOEXP_NIB{gi.strap_val}};
    end else if (gi.wr_en) begin
      unique case (gi.wr_kind)
        KIND_OUT:  gi.out_reg <= gi.wr_data;
        KIND_DIR:  gi.dir     <= gi.wr_data;
        KIND_MASK: gi.mask    <= gi.wr_data;
        KIND_IN:   gi.out_reg <= gi.out_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out <= `IOEXP_OUT_RST;
      pin_oe  <= `IOEXP_OUT_RST;
    end else if (OPEN_DRAIN) begin
      // Open drain only pulls low; a high level is left to the pull-up
      pin_out <= `IOEXP_OUT_RST;
      pin_oe  <= ~gi.dir & ~gi.out_reg;
    end else begin
      pin_out <= gi.out_reg;
      pin_oe  <= ~gi.dir;
    end
  end

  // ----------------------------------------------------------------------
  // Transition detection
  // ----------------------------------------------------------------------
  // Only unmasked inputs count, so writes to outputs never raise an alert
  assign diff = (gi.pin_in ^ gi.snapshot) & gi.dir & ~gi.mask;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gi.snapshot <= `IOEXP_OUT_RST;
      gi.pending  <= 1'b0;
    end else if (gi.capture || gi.strap_load) begin
      // A change in this very cycle is already in the new snapshot
      gi.snapshot <= gi.pin_in;
      gi.pending  <= 1'b0;
    end else if (diff != `IOEXP_OUT_RST) begin
      gi.pending  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_input_no_drive: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    gi.dir != `IOEXP_DIR_RST |=> (pin_oe & $past(gi.dir)) == 4'h0)
    else $error("input port is being driven");

  chk_write_nibble: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    gi.wr_en && gi.wr_kind == KIND_OUT && !gi.strap_load
      |=> gi.out_reg == $past(gi.wr_data))
    else $error("output write not applied");

  chk_mask_blocks: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !gi.pending && diff == 4'h0 |=> !gi.pending)
    else $error("masked or output change raised a flag");

  chk_change_latch: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    diff != 4'h0 && !gi.capture && !gi.strap_load
      |=> gi.pending ##1 (gi.pending || $past(gi.capture || gi.strap_load)))
    else $error("input change not latched");

  chk_capture_snap: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    gi.capture |=> gi.snapshot == $past(gi.pin_in) && !gi.pending)
    else $error("snapshot not taken on read");
endmodule

// >>> hw/ioexp_top.sv
// Serial slave front end and register map of the eight-port expander
`include "ioexp_defs.svh"
// How it works
// - Only the upper nibble of data counts
// - Address 10110, strap pin, then zero
// - Eighth address bit: zero write, one read
// - First written byte selects the register
// - Ninth pulse is acknowledge, held low
// - Device acks received bytes; master acks reads
// - Direction bit set makes port an input
// - Mask bit set silences that port's changes
// - Each further written byte updates selected register, except for 00h..01h
// - Selected group's ports sampled at read address acknowledge for 00h..03h
// - Selected group's pending flag cleared at read address acknowledge for 00h..03h
// - Read of 00h..03h restarts detection; snapshot sent for 00h..01h
// - Changes during shifting compare to new snapshot
// - Unmasked input change latches alert low
// - Each group keeps its own pending change
// - Bus reset aborts transfer, alert untouched
// - Commands 00h..07h map the eight registers
module ioexp_top (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_sel,
  input  wire logic       bus_reset_n,
  input  wire logic [3:0] open_drain_group_in,
  output logic      [3:0] open_drain_group_out,
  output logic      [3:0] open_drain_group_oe,
  input  wire logic [3:0] push_pull_group_in,
  output logic      [3:0] push_pull_group_out,
  output logic      [3:0] push_pull_group_oe,
  output logic            change_alert_n
);
  import ioexp_pkg::*;

  logic [`IOEXP_SYNC_W-1:0] sync1;
  logic [`IOEXP_SYNC_W-1:0] sync2;
  logic                     scl_s;
  logic                     sda_s;
  logic                     scl_q;
  logic                     sda_q;
  logic                     brst_n_s;
  logic                     ad_s;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_det;
  logic                     stop_det;
  ioexp_state_t             state;
  ioexp_phase_t             phase;
  logic [3:0]               cnt;
  logic [7:0]               sh;
  logic [7:0]               cmd;
  logic                     rw_read;
  logic                     nack;
  logic [1:0]               strap_cnt;
  logic [6:0]               own_addr;
  logic                     addr_hit;
  logic                     byte_end;
  logic                     ack_addr_rd;
  logic                     cmd_done;
  logic                     data_wr;
  logic                     cmd_ok;
  logic                     grp_b;
  ioexp_kind_t              kind;
  logic [3:0]               sel_nib;
  logic [7:0]               rd_byte;

  ioexp_grp_if gi_a ();
  ioexp_grp_if gi_b ();

  // ----------------------------------------------------------------------
  // Pin synchronisers and bus edge detection
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= `IOEXP_SYNC_RST;
      sync2 <= `IOEXP_SYNC_RST;
    end else begin
      sync1 <= {scl, sda_in, bus_reset_n, addr_sel,
                open_drain_group_in, push_pull_group_in};
      sync2 <= sync1;
    end
  end

  assign scl_s    = sync2[11];
  assign sda_s    = sync2[10];
  assign brst_n_s = sync2[9];
  assign ad_s     = sync2[8];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Data is sampled only on a clock rise, so it must be stable while high
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------------
  assign own_addr    = {`IOEXP_ADDR_HI, ad_s, `IOEXP_ADDR_LO};
  assign addr_hit    = sh[7:1] == own_addr;
  assign byte_end    = state == ST_RX && scl_fall && cnt == `IOEXP_BYTE_BITS;
  assign ack_addr_rd = byte_end && phase == PH_ADDR && addr_hit && sh[0];
  assign cmd_done    = byte_end && phase == PH_CMD;
  assign data_wr     = byte_end && phase == PH_DATA;
  assign cmd_ok      = cmd[`IOEXP_CMD_TOP:`IOEXP_CMD_HI] == 5'h00;
  assign grp_b       = cmd[`IOEXP_CMD_GRP];
  assign kind        = ioexp_kind_t'(cmd[2:1]);

  // ----------------------------------------------------------------------
  // Serial state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      phase <= PH_ADDR;
      cnt   <= 4'h0;
      sh    <= 8'h00;
      nack  <= 1'b0;
    end else if (!brst_n_s || stop_det) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else if (start_det) begin
      // A repeated start lands here too and begins a new address byte
      state <= ST_RX;
      phase <= PH_ADDR;
      cnt   <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE, ST_IGNORE: begin
          cnt <= 4'h0;
        end
        ST_RX: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            if (phase != PH_ADDR || addr_hit)
              state <= ST_ACK;
            else
              state <= ST_IGNORE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt <= 4'h0;
            if (rw_read) begin
              state <= ST_TX;
              sh    <= rd_byte;
            end else begin
              state <= ST_RX;
              phase <= (phase == PH_ADDR) ? PH_CMD : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            sh  <= {sh[6:0], 1'b0};
            cnt <= cnt + 4'h1;
            if (cnt == `IOEXP_LAST_TX)
              state <= ST_MACK;
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nack <= sda_s;
          end else if (scl_fall) begin
            cnt <= 4'h0;
            if (nack) begin
              state <= ST_IGNORE;
            end else begin
              state <= ST_TX;
              sh    <= rd_byte;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Open-drain data line: low during ack and for zero bits sent
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      sda_oe <= 1'b0;
    else
      sda_oe <= state == ST_ACK || (state == ST_TX && !sh[7]);
  end
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------------
  // Direction flag and command byte
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      rw_read <= 1'b0;
    else if (byte_end && phase == PH_ADDR && addr_hit)
      rw_read <= sh[0];
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      cmd <= 8'h00;
    else if (cmd_done)
      cmd <= sh;
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb begin
    sel_nib = 4'h0;
    unique case (kind)
      KIND_IN:   sel_nib = grp_b ? gi_b.snapshot : gi_a.snapshot;
      KIND_OUT:  sel_nib = grp_b ? gi_b.out_reg  : gi_a.out_reg;
      KIND_DIR:  sel_nib = grp_b ? gi_b.dir      : gi_a.dir;
      KIND_MASK: sel_nib = grp_b ? gi_b.mask     : gi_a.mask;
    endcase
  end
  // Unused codes read back as zero
  assign rd_byte = cmd_ok ? {sel_nib, 4'h0} : 8'h00;

  // ----------------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------------
  // Waits for the strap to clear the synchroniser before loading it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      strap_cnt <= 2'h0;
    else if (strap_cnt != 2'h3)
      strap_cnt <= strap_cnt + 2'h1;
  end

  // ----------------------------------------------------------------------
  // Port groups
  // ----------------------------------------------------------------------
  assign gi_a.pin_in     = sync2[7:4];
  assign gi_b.pin_in     = sync2[3:0];
  assign gi_a.wr_data    = sh[7:`IOEXP_NIB_LSB];
  assign gi_b.wr_data    = sh[7:`IOEXP_NIB_LSB];
  assign gi_a.wr_kind    = kind;
  assign gi_b.wr_kind    = kind;
  assign gi_a.wr_en      = data_wr && cmd_ok && !grp_b;
  assign gi_b.wr_en      = data_wr && cmd_ok && grp_b;
  assign gi_a.capture    = ack_addr_rd && cmd_ok && !cmd[2] && !grp_b;
  assign gi_b.capture    = ack_addr_rd && cmd_ok && !cmd[2] && grp_b;
  assign gi_a.strap_load = strap_cnt == `IOEXP_STRAP_AT;
  assign gi_b.strap_load = strap_cnt == `IOEXP_STRAP_AT;
  assign gi_a.strap_val  = ad_s;
  assign gi_b.strap_val  = ad_s;

  ioexp_grp #(.OPEN_DRAIN(1'b1)) u_grp_a (
    .gi      (gi_a),
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_out (open_drain_group_out),
    .pin_oe  (open_drain_group_oe)
  );

  ioexp_grp #(.OPEN_DRAIN(1'b0)) u_grp_b (
    .gi      (gi_b),
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_out (push_pull_group_out),
    .pin_oe  (push_pull_group_oe)
  );

  // Bus reset does not reach this flop, so the alert survives it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      change_alert_n <= 1'b1;
    else
      change_alert_n <= !(gi_a.pending || gi_b.pending);
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_ack_drive;
    state == ST_ACK ##1 sda_oe;
  endsequence

  sequence s_stay_off;
    state == ST_IGNORE ##1 !sda_oe [*2];
  endsequence

  chk_addr_ack: assert property (
    @(posedge ref_clk) disable iff (sys_rst || !brst_n_s)
    byte_end && phase == PH_ADDR && addr_hit && !stop_det && !start_det
      |=> s_ack_drive)
    else $error("own address not acknowledged");

  chk_addr_miss: assert property (
    @(posedge ref_clk) disable iff (sys_rst || !brst_n_s)
    byte_end && phase == PH_ADDR && !addr_hit && !stop_det && !start_det
      |=> s_stay_off)
    else $error("foreign address acknowledged");

  chk_dir_flag: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    byte_end && phase == PH_ADDR && addr_hit |=> rw_read == $past(sh[0]))
    else $error("direction flag not taken");

  chk_cmd_latch: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    cmd_done |=> cmd == $past(sh))
    else $error("command byte not stored");

  chk_ack_hold: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state == ST_ACK && $past(state) == ST_ACK |-> sda_oe)
    else $error("acknowledge not held low");

  chk_bus_reset: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !brst_n_s |=> state == ST_IDLE ##1 !sda_oe)
    else $error("bus reset did not abort transfer");

  chk_group_alert: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    gi_a.capture && gi_b.pending |=> ##1 !change_alert_n)
    else $error("other group alert lost");
endmodule

// >>> tb/ioexp_master.sv
// Serial bus master model that drives the expander's clock and data lines
module ioexp_master (
  input  wire logic sda,
  output logic      scl,
  output logic      m_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half period in ns; the clock stands high outside frames
  int half = 64;

  initial begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Bit level
  // ----------------------------------------------------------------------
  // Data moves only while the clock is low and is sampled late in the high
  // phase, so the slave's delayed answer has settled by then
  task automatic bit_io(input logic b, output logic r);
    #(half / 2) m_oe = ~b;
    #(half / 2) scl = 1'b1;
    #(half - 8) r = sda;
    #8 scl = 1'b0;
  endtask

  task automatic start();
    #(half) m_oe = 1'b0;
    #(half) scl = 1'b1;
    #(half / 2) m_oe = 1'b1;
    #(half / 2) scl = 1'b0;
  endtask

  task automatic stop();
    #(half / 2) m_oe = 1'b1;
    #(half / 2) scl = 1'b1;
    #(half / 2) m_oe = 1'b0;
    #(half);
  endtask

  // ----------------------------------------------------------------------
  // Byte level: nine pulses per byte, MSB first
  // ----------------------------------------------------------------------
  task automatic send(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, nack);
  endtask

  // Master acknowledges a read byte only when last is low; a high bit ends the read
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// >>> tb/ioexp_top_tb.sv
// Self-checking bench for the serial I/O expander
module ioexp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [7:0] cmd;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [3:0] odoe;
  } ioexp_row_t;

  logic       ref_clk;
  logic       sys_rst;
  logic       addr_sel;
  logic       bus_reset_n;
  logic [3:0] ext_a;
  logic [3:0] ext_b;
  logic       sda_out;
  logic       sda_oe;
  logic       scl;
  logic       m_oe;
  logic [3:0] od_out;
  logic [3:0] od_oe;
  logic [3:0] pp_out;
  logic [3:0] pp_oe;
  logic       alert_n;
  logic [7:0] d;
  logic       nk;
  int         mismatches;
  int         n_checks;

  // Pull-up on the data line; open-drain pins float high unless pulled
  wire       sda   = ~((sda_oe & ~sda_out) | m_oe);
  wire [3:0] od_in = (od_oe & od_out) | (~od_oe & ext_a);
  wire [3:0] pp_in = (pp_oe & pp_out) | (~pp_oe & ext_b);

  // Device address with the strap high: 10110, 1, 0
  ioexp_row_t rows [9] = '{
    '{8'h02, 8'ha5, 8'ha0, 4'h5}, '{8'h03, 8'h3c, 8'h30, 4'h5},
    '{8'h06, 8'hf0, 8'hf0, 4'h5}, '{8'h07, 8'hf0, 8'hf0, 4'h5},
    '{8'h04, 8'hf0, 8'hf0, 4'h0}, '{8'h05, 8'h00, 8'h00, 4'h0},
    '{8'h00, 8'h55, 8'hf0, 4'h0}, '{8'h01, 8'h55, 8'h30, 4'h0},
    '{8'h08, 8'hf0, 8'h00, 4'h0}
  };

  ioexp_top ioexp_top_inst (
    .ref_clk              (ref_clk),
    .sys_rst              (sys_rst),
    .scl                  (scl),
    .sda_in               (sda),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .addr_sel             (addr_sel),
    .bus_reset_n          (bus_reset_n),
    .open_drain_group_in  (od_in),
    .open_drain_group_out (od_out),
    .open_drain_group_oe  (od_oe),
    .push_pull_group_in   (pp_in),
    .push_pull_group_out  (pp_out),
    .push_pull_group_oe   (pp_oe),
    .change_alert_n       (alert_n)
  );

  ioexp_master ioexp_master_inst (
    .sda  (sda),
    .scl  (scl),
    .m_oe (m_oe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] wd);
    logic n0, n1, n2;
    ioexp_master_inst.start();
    ioexp_master_inst.send(8'hb4, n0);
    ioexp_master_inst.send(cmd, n1);
    ioexp_master_inst.send(wd, n2);
    ioexp_master_inst.stop();
    check8({7'h00, n0 | n1 | n2}, 8'h00);
  endtask

  task automatic rd_reg(input logic [7:0] cmd, output logic [7:0] rd);
    logic n0, n1, n2;
    ioexp_master_inst.start();
    ioexp_master_inst.send(8'hb4, n0);
    ioexp_master_inst.send(cmd, n1);
    ioexp_master_inst.start();
    ioexp_master_inst.send(8'hb5, n2);
    ioexp_master_inst.recv(1'b1, rd);
    ioexp_master_inst.stop();
    check8({7'h00, n0 | n1 | n2}, 8'h00);
  endtask

  // Pin changes land shortly after a clock edge, then have time to settle
  task automatic set_pins(input logic [3:0] a, input logic [3:0] b);
    @(posedge ref_clk) #1;
    ext_a = a;
    ext_b = b;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    #600us;
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    addr_sel = 1'b1;
    bus_reset_n = 1'b1;
    ext_a = 4'hf;
    ext_b = 4'hf;
    mismatches = 0;
    n_checks = 0;
    repeat (20) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    check8({od_oe, pp_oe}, 8'h0f);
    check8({pp_out, 3'h0, alert_n}, 8'hf1);
    check8({od_out, 4'h0}, 8'h00);
    foreach (rows[i]) begin
      wr_reg(rows[i].cmd, rows[i].wd);
      rd_reg(rows[i].cmd, d);
      check8(d, rows[i].rd);
      check8({4'h0, od_oe}, {4'h0, rows[i].odoe});
    end
    // Two data bytes in one write, both to output group B
    ioexp_master_inst.start();
    ioexp_master_inst.send(8'hb4, nk);
    ioexp_master_inst.send(8'h03, nk);
    ioexp_master_inst.send(8'h50, nk);
    #200 check8({4'h0, pp_out}, 8'h05);
    ioexp_master_inst.send(8'ha0, nk);
    ioexp_master_inst.stop();
    check8({3'h0, nk, pp_out}, 8'h0a);
    check8({7'h00, alert_n}, 8'h01);
    // Foreign address at a slower bus clock: no ack, data ignored
    ioexp_master_inst.half = 96;
    ioexp_master_inst.start();
    ioexp_master_inst.send(8'hb0, nk);
    check8({7'h00, nk}, 8'h01);
    ioexp_master_inst.send(8'h03, nk);
    ioexp_master_inst.send(8'hf0, nk);
    ioexp_master_inst.stop();
    rd_reg(8'h03, d);
    check8(d, 8'ha0);
    ioexp_master_inst.half = 64;
    // Unmasked input change on group A raises the latched alert
    wr_reg(8'h06, 8'h00);
    rd_reg(8'h00, d);
    check8({d[7:1], alert_n}, 8'hf1);
    set_pins(4'he, 4'hf);
    check8({7'h00, alert_n}, 8'h00);
    // Bus reset mid-write aborts the transfer and keeps the alert
    ioexp_master_inst.start();
    ioexp_master_inst.send(8'hb4, nk);
    ioexp_master_inst.send(8'h03, nk);
    @(posedge ref_clk) #1 bus_reset_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 bus_reset_n = 1'b1;
    ioexp_master_inst.send(8'h50, nk);
    ioexp_master_inst.stop();
    check8({6'h00, nk, alert_n}, 8'h02);
    rd_reg(8'h03, d);
    check8(d, 8'ha0);
    rd_reg(8'h00, d);
    check8({d[7:1], alert_n}, 8'he1);
    // Group B as masked inputs, then unmasked
    wr_reg(8'h05, 8'hf0);
    check8({4'h0, pp_oe}, 8'h00);
    rd_reg(8'h01, d);
    check8(d, 8'hf0);
    set_pins(4'he, 4'hd);
    check8({7'h00, alert_n}, 8'h01);
    wr_reg(8'h07, 8'h00);
    repeat (10) @(posedge ref_clk);
    check8({7'h00, alert_n}, 8'h00);
    rd_reg(8'h00, d);
    check8({d[7:1], alert_n}, 8'he0);
    rd_reg(8'h01, d);
    check8({d[7:1], alert_n}, 8'hd1);
    // A change while the byte shifts out is held against the new snapshot
    ioexp_master_inst.start();
    ioexp_master_inst.send(8'hb4, nk);
    ioexp_master_inst.send(8'h00, nk);
    ioexp_master_inst.start();
    ioexp_master_inst.send(8'hb5, nk);
    set_pins(4'hf, 4'hd);
    ioexp_master_inst.recv(1'b1, d);
    ioexp_master_inst.stop();
    check8(d, 8'he0);
    repeat (10) @(posedge ref_clk);
    check8({7'h00, alert_n}, 8'h00);
    rd_reg(8'h00, d);
    check8({d[7:1], alert_n}, 8'hf1);
    close_out();
  end
endmodule
